// [design/cps_config_port_sequencer.sv]
// Configuration port sequencer: program request filter, readiness and
// completion indicators, slave serial loading and master serial flash read.
// Assumes every pin input is asynchronous to clock; open-drain pins are
// resolved outside from the _out/_oe pairs.
//
// Summary of operation
// - A low program request starts a fresh configuration sequence.
// - Program request low pulses of 25 ns or less are ignored.
// - Readiness indicator is open drain, pull-up enabled during configuration.
// - Completion indicator is open drain, released when loading has finished.
// - Slave mode: host drives serial clock; master mode: device drives it.
// - Master mode: device drives flash select low while reading the flash.
// - Slave data enters on serial in; master sends there, receives on serial out.
`timescale 1ns/1ns
`default_nettype none

module cps_config_port_sequencer #(
  parameter int CLEAR_CYCLES = cps_pkg::INIT_LOW_CYC,
  parameter int CONFIG_BITS  = 1024
) (
  input  wire logic           clock,
  input  wire logic           reset_n,
  input  wire logic           program_request_n,
  input  wire logic           master_multi_boot_mode,
  input  wire logic           ready_for_config_n_in,
  output logic                ready_for_config_n_out,
  output logic                ready_for_config_n_oe,
  output logic                ready_pullup_enable,
  input  wire logic           config_done_in,
  output logic                config_done_out,
  output logic                config_done_oe,
  input  wire logic           config_serial_clock_in,
  output logic                config_serial_clock_out,
  output logic                config_serial_clock_oe,
  input  wire logic           slave_select_n,
  output logic                flash_select_out_n,
  input  wire logic           serial_in_line_in,
  output logic                serial_in_line_out,
  output logic                serial_in_line_oe,
  input  wire logic           serial_out_line_in,
  output logic                serial_out_line_out,
  output logic                serial_out_line_oe,
  output logic                user_io_enable,
  output cps_pkg::cps_byte_type config_byte
);

  // ****************************************************************
  // State
  // ****************************************************************
  cps_pkg::cps_regs_type s_q;
  cps_pkg::cps_regs_type s_d;
  logic                  accept;
  logic                  rise_ph;
  logic                  fall_ph;
  logic                  take;
  logic                  bit_in;

  // Next state: synchronisers, filter, sequence
  always_comb begin
    s_d      = s_q;
    accept   = 1'h0;
    take     = 1'h0;
    bit_in   = 1'h0;
    rise_ph  = (s_q.cnt == 16'(cps_pkg::MCLK_HALF_CYC - 1));
    fall_ph  = (s_q.cnt == 16'(2 * cps_pkg::MCLK_HALF_CYC - 1));
    s_d.byte_out.valid = 1'h0;
    // Two flops on every sampled pin, three on the serial clock; only stage 1 and later are read
    s_d.prog_s = {s_q.prog_s[0], program_request_n};
    s_d.sck_s  = {s_q.sck_s[1:0], config_serial_clock_in};
    s_d.sdi_s  = {s_q.sdi_s[0], serial_in_line_in};
    s_d.sdo_s  = {s_q.sdo_s[0], serial_out_line_in};
    s_d.ssn_s  = {s_q.ssn_s[0], slave_select_n};
    s_d.mode_s = {s_q.mode_s[0], master_multi_boot_mode};
    // Count consecutive low samples; accept once, on the sample after the reject window
    if (s_q.prog_s[1]) begin
      s_d.prog_cnt = 3'h0;
    end else if (s_q.prog_cnt != cps_pkg::PRGM_ACCEPT_CNT + 3'h1) begin
      s_d.prog_cnt = s_q.prog_cnt + 3'h1;
    end
    accept = !s_q.prog_s[1] && (s_q.prog_cnt == cps_pkg::PRGM_ACCEPT_CNT);
    case (s_q.st)
      cps_pkg::CPS_CLEAR: begin
        // A request still held low keeps the clear running
        s_d.cnt = s_q.prog_s[1] ? s_q.cnt + 16'h0001 : 16'h0000;
        if (s_q.cnt == 16'(CLEAR_CYCLES - 1)) begin
          s_d.st     = cps_pkg::CPS_WAIT;
          s_d.cnt    = 16'h0000;
          s_d.bits   = 16'h0000;
          s_d.master = s_q.mode_s[1];
        end
      end
      cps_pkg::CPS_WAIT: begin
        if (!s_q.master) begin
          s_d.st = cps_pkg::CPS_LOAD;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.cnt == 16'(cps_pkg::CS_DELAY_CYC - 1)) begin
            s_d.csn = 1'h0;
          end
          // Clock starts well after the select, giving the flash its set-up
          if (s_q.cnt == 16'(cps_pkg::MCLK_FIRST_CYC - 1)) begin
            s_d.st    = cps_pkg::CPS_CMD;
            s_d.cnt   = 16'h0000;
            s_d.shreg = {cps_pkg::FLASH_READ_CMD, cps_pkg::FLASH_START_ADDR};
            s_d.dout  = cps_pkg::FLASH_READ_CMD[7];
          end
        end
      end
      cps_pkg::CPS_CMD: begin
        s_d.cnt = fall_ph ? 16'h0000 : s_q.cnt + 16'h0001;
        if (rise_ph) begin
          s_d.sclk = 1'h1;
          s_d.bits = s_q.bits + 16'h0001;
        end else if (fall_ph) begin
          s_d.sclk  = 1'h0;
          s_d.shreg = {s_q.shreg[30:0], 1'h0};
          s_d.dout  = s_q.shreg[30];
          if (s_q.bits == 16'(cps_pkg::CMD_BITS)) begin
            s_d.st   = cps_pkg::CPS_LOAD;
            s_d.bits = 16'h0000;
            s_d.dout = 1'h0;
          end
        end
      end
      cps_pkg::CPS_LOAD: begin
        if (s_q.master) begin
          s_d.cnt = fall_ph ? 16'h0000 : s_q.cnt + 16'h0001;
          if (rise_ph) begin
            s_d.sclk = 1'h1;
          end else if (fall_ph) begin
            s_d.sclk = 1'h0;
          end
          take   = rise_ph;
          bit_in = s_q.sdo_s[1];
        end else begin
          // Host clock edge seen on the synchronised copy; select gates it
          take   = s_q.sck_s[1] && !s_q.sck_s[2] && !s_q.ssn_s[1];
          bit_in = s_q.sdi_s[1];
        end
        if (take) begin
          s_d.shreg = {s_q.shreg[30:0], bit_in};
          s_d.bits  = s_q.bits + 16'h0001;
          if (s_q.bits[2:0] == 3'h7) begin
            s_d.byte_out.valid = 1'h1;
            s_d.byte_out.data  = {s_q.shreg[6:0], bit_in};
          end
          if (s_q.bits == 16'(CONFIG_BITS - 1)) begin
            s_d.st   = cps_pkg::CPS_DONE;
            s_d.csn  = 1'h1;
            s_d.sclk = 1'h0;
          end
        end
      end
      cps_pkg::CPS_DONE: begin
        s_d.cnt = 16'h0000;
      end
      default: begin
        s_d.st = cps_pkg::CPS_CLEAR;
      end
    endcase
    // A new request overrides whatever the sequence was doing
    if (accept) begin
      s_d.st   = cps_pkg::CPS_CLEAR;
      s_d.cnt  = 16'h0000;
      s_d.csn  = 1'h1;
      s_d.sclk = 1'h0;
      s_d.dout = 1'h0;
    end
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= cps_pkg::CPS_REGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Open-drain pins only ever pull low; the board supplies the high level
  assign ready_for_config_n_out  = 1'h0;
  assign ready_for_config_n_oe   = (s_q.st == cps_pkg::CPS_CLEAR);
  assign ready_pullup_enable     = (s_q.st != cps_pkg::CPS_DONE);
  assign config_done_out         = 1'h0;
  assign config_done_oe          = (s_q.st != cps_pkg::CPS_DONE);
  assign config_serial_clock_out = s_q.sclk;
  assign config_serial_clock_oe  = s_q.master && (s_q.st != cps_pkg::CPS_CLEAR);
  assign flash_select_out_n      = s_q.csn;
  assign serial_in_line_out      = s_q.dout;
  assign serial_in_line_oe       = s_q.master && (s_q.st == cps_pkg::CPS_CMD);
  // No read-back path in slave mode, so the output line is never driven
  assign serial_out_line_out     = 1'h0;
  assign serial_out_line_oe      = 1'h0;
  assign user_io_enable          = (s_q.st == cps_pkg::CPS_DONE);
  assign config_byte             = s_q.byte_out;

  // ****************************************************************
  // Checks
  // ****************************************************************
  localparam int CS_LO = cps_pkg::CS_DELAY_CYC;
  localparam int CS_HI = cps_pkg::CS_DELAY_MAX_CYC;
  default clocking cps_cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence prog_first_low;
    !s_q.prog_s[1] && (s_q.prog_cnt == 3'h0);
  endsequence
  sequence prog_held_low;
    !s_q.prog_s[1] [*3];
  endsequence

  AST_PROG_STARTS: assert property (prog_first_low ##1 prog_held_low
    |=> (s_q.st == cps_pkg::CPS_CLEAR) && config_done_oe)
    else $error("program request did not restart configuration");
  AST_SHORT_REJECT: assert property (accept
    |-> $past(!s_q.prog_s[1], 1) && $past(!s_q.prog_s[1], 2) && $past(!s_q.prog_s[1], 3))
    else $error("program pulse accepted too early");
  AST_DONE_LOW_FAST: assert property ((!program_request_n) [*8]
    |-> ##[0:7] config_done_oe)
    else $error("completion not pulled low in time");
  AST_PULLUP: assert property (!ready_for_config_n_oe && !user_io_enable
    |-> ready_pullup_enable)
    else $error("pull-up off during configuration");
  AST_DONE_RELEASE: assert property ($rose(user_io_enable)
    |-> !config_done_oe && $past(s_q.st == cps_pkg::CPS_LOAD))
    else $error("completion released outside end of load");
  AST_CLK_DIR: assert property (config_serial_clock_oe |-> s_q.master)
    else $error("serial clock driven in slave mode");
  AST_CS_DELAY: assert property ($fell(ready_for_config_n_oe) && s_q.mode_s[1]
    |-> ##[CS_LO:CS_HI] !flash_select_out_n)
    else $error("flash select late");
  AST_CS_MASTER: assert property (!flash_select_out_n |-> s_q.master && !user_io_enable)
    else $error("flash select low outside master read");
  AST_SI_DIR: assert property (serial_in_line_oe |-> s_q.master && !flash_select_out_n)
    else $error("serial in line driven wrongly");
  AST_READY_CLEAR: assert property (accept |=> ready_for_config_n_oe [*2])
    else $error("readiness not held low during clear");
  AST_NO_CLK_IN_CLEAR: assert property (config_serial_clock_out |-> !ready_for_config_n_oe)
    else $error("clocking during memory clear");
  AST_IO_OFF: assert property (config_done_oe |-> !user_io_enable)
    else $error("user I/O enabled before completion");

endmodule

`default_nettype wire

// [design/cps_pkg.sv]
// Package for the configuration port sequencer: timing counts, flash
// command, state encoding and the packed carriers shared by the design.
// Assumes a 100 MHz system clock; every count except MCLK_HALF_CYC is derived from the clock period.
package cps_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  // Longest program pulse that must be ignored, rounded up to samples
  localparam int PRGM_REJECT_NS  = 25;
  localparam int PRGM_REJECT_CYC = (PRGM_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] PRGM_ACCEPT_CNT = 3'(PRGM_REJECT_CYC);
  // Latest completion pull-down after the program request, rounded down
  localparam int DONE_LOW_MAX_NS  = 150;
  localparam int DONE_LOW_MAX_CYC = DONE_LOW_MAX_NS / CLK_PERIOD_NS;
  // Memory clear time while the readiness indicator is held low
  localparam int INIT_LOW_NS      = 55000;
  localparam int INIT_LOW_CYC     = INIT_LOW_NS / CLK_PERIOD_NS;
  // Readiness release to flash select low, least time rounded up
  localparam int CS_DELAY_NS      = 100;
  localparam int CS_DELAY_CYC     = (CS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_DELAY_MAX_NS  = 200;
  localparam int CS_DELAY_MAX_CYC = CS_DELAY_MAX_NS / CLK_PERIOD_NS;
  // Readiness release to first serial clock edge, least time rounded up
  localparam int MCLK_FIRST_NS    = 750;
  localparam int MCLK_FIRST_CYC   = (MCLK_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Half period of the driven serial clock in system cycles
  localparam int MCLK_HALF_CYC    = 4;
  localparam int CNT_W            = 16;

  // ****************************************************************
  // Flash read command
  // ****************************************************************
  localparam logic [7:0]  FLASH_READ_CMD   = 8'h03;
  localparam logic [23:0] FLASH_START_ADDR = 24'h00_0000;
  localparam int          CMD_BITS         = 32;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    CPS_CLEAR,
    CPS_WAIT,
    CPS_CMD,
    CPS_LOAD,
    CPS_DONE
  } cps_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cps_byte_type;

  typedef struct packed {
    cps_state_type    st;
    logic             master;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] bits;
    logic [31:0]      shreg;
    logic             sclk;
    logic             csn;
    logic             dout;
    logic [2:0]       prog_cnt;
    logic [1:0]       prog_s;
    logic [2:0]       sck_s;
    logic [1:0]       sdi_s;
    logic [1:0]       sdo_s;
    logic [1:0]       ssn_s;
    logic [1:0]       mode_s;
    cps_byte_type     byte_out;
  } cps_regs_type;

  localparam cps_regs_type CPS_REGS_RESET = '{
    st:      CPS_CLEAR,
    csn:     1'h1,
    prog_s:  2'h3,
    ssn_s:   2'h3,
    default: '0
  };

endpackage

// [test/cps_flash_model.sv]
// Behavioural serial configuration flash for the master serial load.
// Assumes the sequencer shifts a 32 bit command MSB first, then samples data on clock rise.
`timescale 1ns/1ns
`default_nettype none
module cps_flash_model #(
  parameter logic [15:0] DATA = 16'hC35A
) (
  input  wire logic        select_n,
  input  wire logic        sck,
  input  wire logic        si,
  output logic             so,
  output logic [31:0]      cmd
);
  int          n;
  logic [15:0] sh;
  // Start state before the first select
  initial begin
    so  = 1'b0;
    cmd = '0;
    n   = 0;
  end
  always @(negedge select_n) begin
    n   = 0;
    cmd = '0;
    sh  = DATA;
  end
  // Command bits arrive on the device's serial in line
  always @(posedge sck) if (!select_n && n < 32) begin
    cmd = {cmd[30:0], si};
    n++;
  end
  // Data changes on the fall so it is settled at the device's rise
  always @(negedge sck) if (!select_n && n >= 32) begin
    so = sh[15];
    sh = {sh[14:0], 1'b0};
  end
  // Released line must not keep the last bit
  always @(posedge select_n) so = ~so;
endmodule
`default_nettype wire

// [test/cps_config_port_sequencer_test.sv]
// Testbench for the configuration port sequencer: request filter, slave and master loads.
// Assumes the sequencer with its in-file assertions and the flash model in test/.
`timescale 1ns/1ns
`default_nettype none
module cps_config_port_sequencer_test;
  logic clock, reset_n, prog_n, mode, host_sck, ssn, host_sdi;
  logic rdy_out, rdy_oe, pu, done_out, done_oe, sck_out, sck_oe, fcs_n;
  logic si_out, si_oe, so_out, so_oe, uio, flash_so;
  logic [31:0] flash_cmd;
  logic [7:0]  bytes[$];
  cps_pkg::cps_byte_type cb;
  int          failures, n_checks, cyc, i;
  // Open-drain pins idle high through their pull-ups
  wire rdy_pin  = rdy_oe ? rdy_out : 1'b1;
  wire done_pin = done_oe ? done_out : 1'b1;
  wire sck_pin  = sck_oe ? sck_out : host_sck;
  wire si_pin   = si_oe ? si_out : host_sdi;
  wire so_pin   = so_oe ? so_out : flash_so;

  cps_config_port_sequencer #(.CLEAR_CYCLES(20), .CONFIG_BITS(16)) dut (
    .clock(clock), .reset_n(reset_n), .program_request_n(prog_n),
    .master_multi_boot_mode(mode), .ready_for_config_n_in(rdy_pin),
    .ready_for_config_n_out(rdy_out), .ready_for_config_n_oe(rdy_oe),
    .ready_pullup_enable(pu), .config_done_in(done_pin), .config_done_out(done_out),
    .config_done_oe(done_oe), .config_serial_clock_in(sck_pin),
    .config_serial_clock_out(sck_out), .config_serial_clock_oe(sck_oe),
    .slave_select_n(ssn), .flash_select_out_n(fcs_n), .serial_in_line_in(si_pin),
    .serial_in_line_out(si_out), .serial_in_line_oe(si_oe),
    .serial_out_line_in(so_pin), .serial_out_line_out(so_out),
    .serial_out_line_oe(so_oe), .user_io_enable(uio), .config_byte(cb));

  cps_flash_model #(.DATA(16'hC35A)) flash (
    .select_n(fcs_n), .sck(sck_out), .si(si_pin), .so(flash_so), .cmd(flash_cmd));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Bytes are collected mid-cycle so a one-cycle valid is neither missed nor raced
  always @(negedge clock) if (cb.valid === 1'b1) bytes.push_back(cb.data);
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      $display("CHECK FAILED at %0t: run did not finish", $time);
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      failures++;
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic request(input int n);
    prog_n = 1'b0;
    cycles(n);
    prog_n = 1'b1;
  endtask
  // Host clock at 125 ns, unrelated to the system clock
  task automatic host_byte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      host_sdi = b[k];
      #62 host_sck = 1'b1;
      #63 host_sck = 1'b0;
    end
  endtask
  task automatic wait_ready;
    for (i = 0; i < 40 && rdy_oe !== 1'b0; i++) cycles(1);
    check(rdy_oe, 1'b0, "ready release");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    cycles(10);
    check(rdy_oe, 1'b1, "ready low in clear");
    check({done_oe, uio, pu, sck_oe}, 4'b1010, "start state");
    check({rdy_out, done_out, so_out, so_oe}, 4'b0000, "open drain levels");
    wait_ready();
    $display("test reset done");
  endtask
  task automatic t_glitch;
    request(2);
    cycles(20);
    check(rdy_oe, 1'b0, "short pulse ignored");
    $display("test glitch done");
  endtask
  task automatic t_slave;
    mode = 1'b0;
    request(6);
    for (i = 0; i < 15 && rdy_oe !== 1'b1; i++) cycles(1);
    check({rdy_oe, done_oe, uio, pu}, 4'b1101, "restart after request");
    wait_ready();
    bytes.delete();
    host_byte(8'hFF);
    ssn = 1'b0;
    host_byte(8'hA5);
    host_byte(8'h3C);
    ssn = 1'b1;
    cycles(10);
    check(bytes.size(), 2, "slave byte count");
    if (bytes.size() == 2) check({bytes[0], bytes[1]}, 16'hA53C, "slave bytes");
    check({done_oe, uio, sck_oe}, 3'b010, "slave done");
    $display("test slave done");
  endtask
  task automatic t_master;
    mode = 1'b1;
    // Long enough to be seen low for eight samples, starting from the done state
    request(8);
    check({done_oe, uio}, 2'b10, "done low after request");
    cycles(3);
    check(uio, 1'b0, "user io off");
    wait_ready();
    bytes.delete();
    for (i = 0; i < 40 && fcs_n !== 1'b0; i++) cycles(1);
    check(i >= cps_pkg::CS_DELAY_CYC - 1 && i <= cps_pkg::CS_DELAY_MAX_CYC - 1, 1'b1,
          "select delay");
    check(sck_oe, 1'b1, "clock driven");
    for (i = 0; i < 800 && done_oe !== 1'b0; i++) cycles(1);
    cycles(4);
    check(flash_cmd, 32'h0300_0000, "flash command");
    check(bytes.size(), 2, "master byte count");
    if (bytes.size() == 2) check({bytes[0], bytes[1]}, 16'hC35A, "master bytes");
    check({fcs_n, uio, done_oe, si_oe, sck_out}, 5'b11000, "master done");
    $display("test master done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    reset_n  = 1'b0;
    prog_n   = 1'b1;
    mode     = 1'b0;
    host_sck = 1'b0;
    ssn      = 1'b1;
    host_sdi = 1'b0;
    cycles(3);
    reset_n = 1'b1;
    t_reset();
    t_glitch();
    t_slave();
    t_master();
    tally_and_finish();
  end
endmodule
`default_nettype wire
